// File: rtl/input_image_pkg.sv
package input_image_pkg;

	localparam int          ADDR_W = 12;
	localparam int          DATA_W = 16;

	// Word offsets of the status image
	localparam logic [11:0] OFS_LEFT_DIO     = 12'h6B0;
	localparam logic [11:0] OFS_RIGHT_DIO    = 12'h6B1;
	localparam logic [11:0] OFS_UP_STATE     = 12'h6B2;
	localparam logic [11:0] OFS_DN_STATE     = 12'h6B3;
	localparam logic [11:0] OFS_TRACK_ONE    = 12'h6B4;
	localparam logic [11:0] OFS_TRACK_TWO    = 12'h6B5;
	localparam logic [11:0] OFS_RESERVED     = 12'h6B6;
	localparam logic [11:0] OFS_LEFT_POS     = 12'h6B7;
	localparam logic [11:0] OFS_RIGHT_POS    = 12'h6B8;
	localparam logic [11:0] OFS_LEFT_SERVO   = 12'h6B9;
	localparam logic [11:0] OFS_RIGHT_SERVO  = 12'h6BA;
	localparam logic [11:0] OFS_LEFT_SPEED   = 12'h6BB;
	localparam logic [11:0] OFS_RIGHT_SPEED  = 12'h6BC;
	localparam logic [11:0] OFS_POL_MASK     = 12'h6C0;
	localparam logic [11:0] OFS_PORT_INPUTS  = 12'h6C1;
	localparam logic [11:0] OFS_IRQ_STATUS   = 12'h6C2;
	localparam logic [11:0] OFS_IRQ_MASK     = 12'h6C3;
	localparam logic [11:0] OFS_LEFT_MOTOR   = 12'h6C4;
	localparam logic [11:0] OFS_RIGHT_MOTOR  = 12'h6C5;

	// Field positions
	localparam int          DIO_SHORT_BIT    = 12;
	localparam int          DIO_OVERCUR_BIT  = 14;
	localparam int          SERVO_DONE_BIT   = 0;
	localparam int          SERVO_RESET_BIT  = 1;
	localparam int          SERVO_CMD1_BIT   = 2;
	localparam int          SPEED_W          = 14;
	localparam int          SPEED_OVER_BIT   = 14;
	localparam int          SPEED_UNDER_BIT  = 15;

	// Interrupt status layout
	localparam int          IRQ_LEFT_SHORT   = 0;
	localparam int          IRQ_LEFT_OVERCUR = 1;
	localparam int          IRQ_RIGHT_SHORT  = 2;
	localparam int          IRQ_RIGHT_OVERCUR = 3;
	localparam int          IRQ_LEFT_DONE    = 4;
	localparam int          IRQ_RIGHT_DONE   = 5;
	localparam int          IRQ_UP_UPDATE    = 6;
	localparam int          IRQ_DN_UPDATE    = 7;
	localparam int          IRQ_W            = 8;

	// Motor state encoding
	localparam logic [1:0]  MOTOR_BRAKED     = 2'h0;
	localparam logic [1:0]  MOTOR_CCW        = 2'h1;
	localparam logic [1:0]  MOTOR_CW         = 2'h2;
	localparam logic [1:0]  MOTOR_COAST      = 2'h3;

	// Neighbour state codes
	localparam logic [7:0]  NB_CLEAR_STOP    = 8'h01;
	localparam logic [7:0]  NB_CLEAR_RUN     = 8'h02;
	localparam logic [7:0]  NB_RESERVED      = 8'h03;
	localparam logic [7:0]  NB_BLOCKED_RUN   = 8'h04;
	localparam logic [7:0]  NB_BLOCKED_STOP  = 8'h05;
	localparam logic [7:0]  NB_BUSY          = 8'h06;

	localparam logic [15:0] WORD_RESET       = 16'h0000;
	localparam logic [15:0] MASK_RESET       = 16'h0000;
	localparam logic [7:0]  IRQ_RESET        = 8'h00;

endpackage : input_image_pkg

// File: rtl/plc_input_status_image.sv
// Functional notes
// - Set bit 12 of port fault word on output short circuit.
// - Set bit 14 of port fault word when an output draws over 1A.
// - Port fault words are read-only; writes to them are ignored.
// - Upstream neighbour state code sits in low byte of its word.
// - Two 16-bit tracking words hold last upstream discharged item identifiers.
// - Neighbour and tracking words update only while neighbour links preserved.
// - Servo position is signed, relative to the motor's zero reference.
// - Servo status bit 0 high when last run done, low while executing.
// - Servo bit 1 echoes command bit 0; left bit 2 echoes bit 1.
// - Measured speed in bits 13:0 of the real speed word.
// - Speed bit 14 flags request above max, bit 15 below min.
// - Motor state bits 1:0: braked, ccw, cw, free coasting.
// - Port input bit is pin level XOR the polarity mask bit.
// - Input LEDs follow the mask-adjusted value, not raw pin level.
// - Fault word valid only in digital I/O mode; only bits 12, 14.
//
// The strobed register port is this design's own decision.
`timescale 1ns/10ps
module plc_input_status_image #(
	parameter int NUM_IN  = 8,
	parameter int NUM_OUT = 2
) (
	input  wire logic                                clk,
	input  wire logic                                rstn,
	input  wire logic [input_image_pkg::ADDR_W-1:0]  addr,
	input  wire logic [input_image_pkg::DATA_W-1:0]  wdata,
	input  wire logic                                wr,
	input  wire logic                                rd,
	output logic      [input_image_pkg::DATA_W-1:0]  rdata,
	output logic                                     irq,
	input  wire logic                                left_dio_mode,
	input  wire logic                                right_dio_mode,
	input  wire logic [NUM_OUT-1:0]                  left_out_short,
	input  wire logic [NUM_OUT-1:0]                  left_out_overcur,
	input  wire logic [NUM_OUT-1:0]                  right_out_short,
	input  wire logic [NUM_OUT-1:0]                  right_out_overcur,
	input  wire logic                                links_preserved,
	input  wire logic                                up_state_valid,
	input  wire logic [7:0]                          up_state_code,
	input  wire logic                                dn_state_valid,
	input  wire logic [7:0]                          dn_state_code,
	input  wire logic                                track_valid,
	input  wire logic [15:0]                         track_one,
	input  wire logic [15:0]                         track_two,
	input  wire logic signed [15:0]                  left_position,
	input  wire logic signed [15:0]                  right_position,
	input  wire logic                                left_servo_busy,
	input  wire logic                                right_servo_busy,
	input  wire logic [1:0]                          left_servo_cmd,
	input  wire logic                                right_servo_cmd,
	input  wire logic [13:0]                         left_speed,
	input  wire logic [13:0]                         right_speed,
	input  wire logic [13:0]                         left_set_speed,
	input  wire logic [13:0]                         right_set_speed,
	input  wire logic [13:0]                         left_max_speed,
	input  wire logic [13:0]                         left_min_speed,
	input  wire logic [13:0]                         right_max_speed,
	input  wire logic [13:0]                         right_min_speed,
	input  wire logic                                left_running,
	input  wire logic                                left_cw,
	input  wire logic                                left_coast,
	input  wire logic                                right_running,
	input  wire logic                                right_cw,
	input  wire logic                                right_coast,
	input  wire logic [NUM_IN-1:0]                   port_pins,
	output logic      [NUM_IN-1:0]                   input_leds
);
	import input_image_pkg::*;

	if (NUM_IN < 1 || NUM_IN > DATA_W) begin : g_check_in
		$error("NUM_IN must lie between 1 and 16");
	end
	if (NUM_OUT < 1) begin : g_check_out
		$error("NUM_OUT must be at least 1");
	end

	////////////////////////////////////////////////////////////////////////
	// Word builders

	function automatic logic [15:0] dio_word(input logic mode,
		input logic short_any, input logic overcur_any);
		logic [15:0] w;
		w = WORD_RESET;
		w[DIO_SHORT_BIT]   = mode & short_any;
		w[DIO_OVERCUR_BIT] = mode & overcur_any;
		return w;
	endfunction : dio_word

	function automatic logic [15:0] speed_word(input logic [13:0] meas,
		input logic [13:0] req, input logic [13:0] vmax,
		input logic [13:0] vmin);
		logic [15:0] w;
		w = WORD_RESET;
		w[SPEED_W-1:0]     = meas;
		w[SPEED_OVER_BIT]  = req > vmax;
		w[SPEED_UNDER_BIT] = req < vmin;
		return w;
	endfunction : speed_word

	function automatic logic [15:0] motor_word(input logic running,
		input logic cw, input logic coast);
		logic [15:0] w;
		w = WORD_RESET;
		if (running) begin
			w[1:0] = cw ? MOTOR_CW : MOTOR_CCW;
		end else begin
			w[1:0] = coast ? MOTOR_COAST : MOTOR_BRAKED;
		end
		return w;
	endfunction : motor_word

	////////////////////////////////////////////////////////////////////////
	// Registers

	logic [15:0]        left_dio_reg;
	logic [15:0]        right_dio_reg;
	logic [15:0]        up_state_reg;
	logic [15:0]        dn_state_reg;
	logic [15:0]        track_one_reg;
	logic [15:0]        track_two_reg;
	logic signed [15:0] left_pos_reg;
	logic signed [15:0] right_pos_reg;
	logic [15:0]        left_servo_reg;
	logic [15:0]        right_servo_reg;
	logic [15:0]        left_speed_reg;
	logic [15:0]        right_speed_reg;
	logic [15:0]        left_motor_reg;
	logic [15:0]        right_motor_reg;
	logic [15:0]        pol_mask_reg;
	logic [15:0]        inputs_reg;
	logic [IRQ_W-1:0]   irq_status_reg;
	logic [IRQ_W-1:0]   irq_mask_reg;
	logic [15:0]        rdata_reg;
	logic               irq_reg;
	logic [NUM_IN-1:0]  leds_reg;
	logic               left_done_reg;
	logic               right_done_reg;

	////////////////////////////////////////////////////////////////////////
	// Next values

	wire  [NUM_IN-1:0]  inputs_logical = port_pins ^ pol_mask_reg[NUM_IN-1:0];
	wire  [15:0]        inputs_next    = {{(DATA_W-NUM_IN){1'b0}},
		inputs_logical};
	wire  [15:0]        left_dio_next  = dio_word(left_dio_mode,
		|left_out_short, |left_out_overcur);
	wire  [15:0]        right_dio_next = dio_word(right_dio_mode,
		|right_out_short, |right_out_overcur);
	wire                up_take        = links_preserved & up_state_valid;
	wire                dn_take        = links_preserved & dn_state_valid;
	wire                track_take     = links_preserved & track_valid;
	wire  [15:0]        up_state_next  = up_take ? {8'h00, up_state_code}
		: up_state_reg;
	wire  [15:0]        dn_state_next  = dn_take ? {8'h00, dn_state_code}
		: dn_state_reg;
	wire  [15:0]        left_servo_next  = {13'h0000, left_servo_cmd[1],
		left_servo_cmd[0], ~left_servo_busy};
	wire  [15:0]        right_servo_next = {14'h0000, right_servo_cmd,
		~right_servo_busy};
	wire                left_done_rise   = ~left_servo_busy & ~left_done_reg;
	wire                right_done_rise  = ~right_servo_busy & ~right_done_reg;

	wire  [IRQ_W-1:0]   irq_events = {dn_take, up_take, right_done_rise,
		left_done_rise, right_dio_next[DIO_OVERCUR_BIT],
		right_dio_next[DIO_SHORT_BIT], left_dio_next[DIO_OVERCUR_BIT],
		left_dio_next[DIO_SHORT_BIT]};
	wire                irq_clear  = rd & (addr == OFS_IRQ_STATUS);
	wire  [IRQ_W-1:0]   irq_status_next = irq_events |
		(irq_clear ? IRQ_RESET : irq_status_reg);
	wire                mask_wr    = wr & (addr == OFS_POL_MASK);
	wire                imask_wr   = wr & (addr == OFS_IRQ_MASK);

	wire  [15:0]        read_word =
		(addr == OFS_LEFT_DIO)    ? left_dio_reg    :
		(addr == OFS_RIGHT_DIO)   ? right_dio_reg   :
		(addr == OFS_UP_STATE)    ? up_state_reg    :
		(addr == OFS_DN_STATE)    ? dn_state_reg    :
		(addr == OFS_TRACK_ONE)   ? track_one_reg   :
		(addr == OFS_TRACK_TWO)   ? track_two_reg   :
		(addr == OFS_LEFT_POS)    ? left_pos_reg    :
		(addr == OFS_RIGHT_POS)   ? right_pos_reg   :
		(addr == OFS_LEFT_SERVO)  ? left_servo_reg  :
		(addr == OFS_RIGHT_SERVO) ? right_servo_reg :
		(addr == OFS_LEFT_SPEED)  ? left_speed_reg  :
		(addr == OFS_RIGHT_SPEED) ? right_speed_reg :
		(addr == OFS_POL_MASK)    ? pol_mask_reg    :
		(addr == OFS_PORT_INPUTS) ? inputs_reg      :
		(addr == OFS_IRQ_STATUS)  ? {8'h00, irq_status_reg} :
		(addr == OFS_IRQ_MASK)    ? {8'h00, irq_mask_reg}   :
		(addr == OFS_LEFT_MOTOR)  ? left_motor_reg  :
		(addr == OFS_RIGHT_MOTOR) ? right_motor_reg :
		WORD_RESET;
	wire  [15:0]        rdata_next = rd ? read_word : WORD_RESET;

	////////////////////////////////////////////////////////////////////////
	// Status image

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			left_dio_reg  <= WORD_RESET;
			right_dio_reg <= WORD_RESET;
			up_state_reg  <= WORD_RESET;
			dn_state_reg  <= WORD_RESET;
			track_one_reg <= WORD_RESET;
			track_two_reg <= WORD_RESET;
		end else begin
			left_dio_reg  <= left_dio_next;
			right_dio_reg <= right_dio_next;
			up_state_reg  <= up_state_next;
			dn_state_reg  <= dn_state_next;
			if (track_take) begin
				track_one_reg <= track_one;
				track_two_reg <= track_two;
			end
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			left_pos_reg    <= WORD_RESET;
			right_pos_reg   <= WORD_RESET;
			left_servo_reg  <= WORD_RESET;
			right_servo_reg <= WORD_RESET;
			left_done_reg   <= 1'b0;
			right_done_reg  <= 1'b0;
		end else begin
			left_pos_reg    <= left_position;
			right_pos_reg   <= right_position;
			left_servo_reg  <= left_servo_next;
			right_servo_reg <= right_servo_next;
			left_done_reg   <= ~left_servo_busy;
			right_done_reg  <= ~right_servo_busy;
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			left_speed_reg  <= WORD_RESET;
			right_speed_reg <= WORD_RESET;
			left_motor_reg  <= WORD_RESET;
			right_motor_reg <= WORD_RESET;
		end else begin
			left_speed_reg  <= speed_word(left_speed, left_set_speed,
				left_max_speed, left_min_speed);
			right_speed_reg <= speed_word(right_speed, right_set_speed,
				right_max_speed, right_min_speed);
			left_motor_reg  <= motor_word(left_running, left_cw,
				left_coast);
			right_motor_reg <= motor_word(right_running, right_cw,
				right_coast);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Inputs, mask, interrupts, read port

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			pol_mask_reg <= MASK_RESET;
			inputs_reg   <= WORD_RESET;
			leds_reg     <= '0;
		end else begin
			if (mask_wr) begin
				pol_mask_reg <= wdata;
			end
			inputs_reg <= inputs_next;
			leds_reg   <= inputs_logical;
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			irq_status_reg <= IRQ_RESET;
			irq_mask_reg   <= IRQ_RESET;
			irq_reg        <= 1'b0;
			rdata_reg      <= WORD_RESET;
		end else begin
			irq_status_reg <= irq_status_next;
			if (imask_wr) begin
				irq_mask_reg <= wdata[IRQ_W-1:0];
			end
			irq_reg   <= |(irq_status_reg & irq_mask_reg);
			rdata_reg <= rdata_next;
		end
	end

	assign rdata      = rdata_reg;
	assign irq        = irq_reg;
	assign input_leds = leds_reg;

	////////////////////////////////////////////////////////////////////////
	// Checks

	a_short_bit: assert property (@(posedge clk) disable iff (!rstn)
		left_dio_mode && (|left_out_short)
		|=> left_dio_reg[DIO_SHORT_BIT])
		else $error("left short circuit not flagged");

	a_overcur_bit: assert property (@(posedge clk) disable iff (!rstn)
		right_dio_mode && (|right_out_overcur)
		|=> right_dio_reg[DIO_OVERCUR_BIT])
		else $error("right over current not flagged");

	a_dio_read_only: assert property (@(posedge clk)
		disable iff (!rstn)
		wr && addr == OFS_LEFT_DIO && !left_dio_mode
		|=> left_dio_reg == WORD_RESET)
		else $error("write reached port fault word");

	a_dio_other_bits: assert property (@(posedge clk)
		disable iff (!rstn)
		(left_dio_reg & ~16'h5000) == WORD_RESET)
		else $error("fault word carries unexpected bits");

	a_up_code: assert property (@(posedge clk) disable iff (!rstn)
		links_preserved && up_state_valid
		|=> up_state_reg == {8'h00, $past(up_state_code)})
		else $error("upstream code not in low byte");

	a_dn_code: assert property (@(posedge clk) disable iff (!rstn)
		links_preserved && dn_state_valid
		|=> dn_state_reg == {8'h00, $past(dn_state_code)})
		else $error("downstream code not in low byte");

	a_links_hold: assert property (@(posedge clk)
		disable iff (!rstn)
		!links_preserved ##1 !links_preserved
		|-> $stable(up_state_reg) && $stable(track_one_reg))
		else $error("neighbour word moved without links");

	a_track_take: assert property (@(posedge clk)
		disable iff (!rstn)
		track_take |=> track_two_reg == $past(track_two)
		&& track_one_reg == $past(track_one))
		else $error("tracking words not captured");

	a_servo_done: assert property (@(posedge clk)
		disable iff (!rstn)
		left_servo_busy [*2] |-> !left_servo_reg[SERVO_DONE_BIT])
		else $error("servo done shown while busy");

	a_servo_echo: assert property (@(posedge clk)
		disable iff (!rstn)
		##1 left_servo_reg[SERVO_CMD1_BIT:SERVO_RESET_BIT]
		== $past(left_servo_cmd))
		else $error("servo command echo wrong");

	a_speed_flags: assert property (@(posedge clk)
		disable iff (!rstn)
		left_set_speed > left_max_speed
		|=> left_speed_reg[SPEED_OVER_BIT]
		&& !left_speed_reg[SPEED_UNDER_BIT] == ($past(left_set_speed)
		>= $past(left_min_speed)))
		else $error("speed range flag wrong");

	a_motor_code: assert property (@(posedge clk)
		disable iff (!rstn)
		right_running && right_cw |=> right_motor_reg[1:0] == MOTOR_CW)
		else $error("motor state encoding wrong");

	a_led_xor: assert property (@(posedge clk)
		disable iff (!rstn)
		##1 input_leds == inputs_reg[NUM_IN-1:0])
		else $error("led differs from reported input");

	a_input_xor: assert property (@(posedge clk)
		disable iff (!rstn)
		##1 inputs_reg[NUM_IN-1:0]
		== ($past(port_pins) ^ $past(pol_mask_reg[NUM_IN-1:0])))
		else $error("input bit not pin xor mask");

	a_irq_level: assert property (@(posedge clk) disable iff (!rstn)
		##1 irq == |($past(irq_status_reg) & $past(irq_mask_reg)))
		else $error("interrupt level wrong");

endmodule : plc_input_status_image

// File: testbench/plc_master_model.sv
`timescale 1ns/10ps
module plc_master_model (
	input  wire logic                               clk,
	output logic      [input_image_pkg::ADDR_W-1:0] addr,
	output logic      [input_image_pkg::DATA_W-1:0] wdata,
	output logic                                    wr,
	output logic                                    rd,
	input  wire logic [input_image_pkg::DATA_W-1:0] rdata
);
	import input_image_pkg::*;

	initial begin
		addr  = 12'h000;
		wdata = 16'h0000;
		wr    = 1'b0;
		rd    = 1'b0;
	end

	////////////////////////////////////////////////////////////////////////
	// One-cycle write; released lines show the inverse value
	task automatic bus_write(input logic [ADDR_W-1:0] a,
		input logic [DATA_W-1:0] d);
		@(posedge clk);
		addr  <= a;
		wdata <= d;
		wr    <= 1'b1;
		@(posedge clk);
		wr    <= 1'b0;
		addr  <= ~a;
		wdata <= ~d;
	endtask : bus_write

	// Data stands only in the cycle after the strobe
	task automatic bus_read(input logic [ADDR_W-1:0] a,
		output logic [DATA_W-1:0] d);
		@(posedge clk);
		addr <= a;
		rd   <= 1'b1;
		@(posedge clk);
		rd   <= 1'b0;
		addr <= ~a;
		#1;
		d = rdata;
	endtask : bus_read

endmodule : plc_master_model

// File: testbench/test_plc_input_status_image.sv
`timescale 1ns/10ps
module test_plc_input_status_image;
	import input_image_pkg::*;

	logic               clk, rstn, wr, rd, irq;
	logic [ADDR_W-1:0]  addr;
	logic [DATA_W-1:0]  wdata, rdata, got;
	logic               left_dio_mode, right_dio_mode, links_preserved;
	logic [1:0]         left_out_short, left_out_overcur;
	logic [1:0]         right_out_short, right_out_overcur;
	logic               up_state_valid, dn_state_valid, track_valid;
	logic [7:0]         up_state_code, dn_state_code, input_leds;
	logic [15:0]        track_one, track_two;
	logic signed [15:0] left_position, right_position;
	logic               left_servo_busy, right_servo_busy, right_servo_cmd;
	logic [1:0]         left_servo_cmd;
	logic [13:0]        left_speed, right_speed;
	logic [13:0]        left_set_speed, right_set_speed;
	logic [13:0]        left_max_speed, left_min_speed;
	logic [13:0]        right_max_speed, right_min_speed;
	logic               left_running, left_cw, left_coast;
	logic               right_running, right_cw, right_coast;
	logic [7:0]         port_pins, pol_mask, up_exp, dn_exp;
	logic [15:0]        t1_exp, t2_exp;
	logic [31:0]        r [0:7];
	int                 seed, failures, total_checks, cycles;

	plc_input_status_image plc_input_status_image_inst (
		.clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr),
		.rd(rd), .rdata(rdata), .irq(irq),
		.left_dio_mode(left_dio_mode), .right_dio_mode(right_dio_mode),
		.left_out_short(left_out_short), .left_out_overcur(left_out_overcur),
		.right_out_short(right_out_short),
		.right_out_overcur(right_out_overcur),
		.links_preserved(links_preserved), .up_state_valid(up_state_valid),
		.up_state_code(up_state_code), .dn_state_valid(dn_state_valid),
		.dn_state_code(dn_state_code), .track_valid(track_valid),
		.track_one(track_one), .track_two(track_two),
		.left_position(left_position), .right_position(right_position),
		.left_servo_busy(left_servo_busy),
		.right_servo_busy(right_servo_busy),
		.left_servo_cmd(left_servo_cmd), .right_servo_cmd(right_servo_cmd),
		.left_speed(left_speed), .right_speed(right_speed),
		.left_set_speed(left_set_speed), .right_set_speed(right_set_speed),
		.left_max_speed(left_max_speed), .left_min_speed(left_min_speed),
		.right_max_speed(right_max_speed), .right_min_speed(right_min_speed),
		.left_running(left_running), .left_cw(left_cw),
		.left_coast(left_coast), .right_running(right_running),
		.right_cw(right_cw), .right_coast(right_coast),
		.port_pins(port_pins), .input_leds(input_leds)
	);

	plc_master_model plc_master_model_inst (
		.clk(clk), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
		.rdata(rdata)
	);

	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	////////////////////////////////////////////////////////////////////////
	task automatic check16(input string name, input logic [15:0] exp,
		input logic [15:0] seen);
		total_checks++;
		if (seen !== exp) begin
			failures++;
			$display("BAD %s expected %h seen %h", name, exp, seen);
		end
	endtask : check16

	task automatic check1(input string name, input logic exp,
		input logic seen);
		total_checks++;
		if (seen !== exp) begin
			failures++;
			$display("BAD %s expected %b seen %b", name, exp, seen);
		end
	endtask : check1

	task automatic complete_run();
		$display("failures %0d total_checks %0d", failures, total_checks);
		if (failures == 0 && total_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : complete_run

	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			failures++;
			complete_run();
		end
	end

	////////////////////////////////////////////////////////////////////////
	function automatic logic [15:0] dio(input logic mode,
		input logic [1:0] sh, input logic [1:0] oc);
		return {1'b0, mode & |oc, 1'b0, mode & |sh, 12'h000};
	endfunction : dio

	function automatic logic [15:0] spd(input logic [13:0] v,
		input logic [13:0] s, input logic [13:0] mx, input logic [13:0] mn);
		return {s < mn, s > mx, v};
	endfunction : spd

	function automatic logic [15:0] mot(input logic run, input logic cw,
		input logic coast);
		if (run) return {14'h0000, cw ? MOTOR_CW : MOTOR_CCW};
		return {14'h0000, coast ? MOTOR_COAST : MOTOR_BRAKED};
	endfunction : mot

	function automatic logic [15:0] exp_word(input logic [11:0] a);
		case (a)
			OFS_LEFT_DIO: return dio(left_dio_mode, left_out_short,
				left_out_overcur);
			OFS_RIGHT_DIO: return dio(right_dio_mode, right_out_short,
				right_out_overcur);
			OFS_UP_STATE: return {8'h00, up_exp};
			OFS_DN_STATE: return {8'h00, dn_exp};
			OFS_TRACK_ONE: return t1_exp;
			OFS_TRACK_TWO: return t2_exp;
			OFS_LEFT_POS: return left_position;
			OFS_RIGHT_POS: return right_position;
			OFS_LEFT_SERVO: return {13'h0000, left_servo_cmd, ~left_servo_busy};
			OFS_RIGHT_SERVO: return {14'h0000, right_servo_cmd,
				~right_servo_busy};
			OFS_LEFT_SPEED: return spd(left_speed, left_set_speed,
				left_max_speed, left_min_speed);
			OFS_RIGHT_SPEED: return spd(right_speed, right_set_speed,
				right_max_speed, right_min_speed);
			OFS_POL_MASK: return {8'h00, pol_mask};
			OFS_PORT_INPUTS: return {8'h00, port_pins ^ pol_mask};
			OFS_LEFT_MOTOR: return mot(left_running, left_cw, left_coast);
			OFS_RIGHT_MOTOR: return mot(right_running, right_cw, right_coast);
			default: return 16'h0000;
		endcase
	endfunction : exp_word

	////////////////////////////////////////////////////////////////////////
	// Idle field: no faults, no pulses, servos busy
	task automatic drive_quiet();
		{left_dio_mode, right_dio_mode, links_preserved} <= 3'h0;
		{left_out_short, left_out_overcur} <= 4'h0;
		{right_out_short, right_out_overcur} <= 4'h0;
		{up_state_valid, dn_state_valid, track_valid} <= 3'h0;
		{up_state_code, dn_state_code} <= 16'h0101;
		{track_one, track_two, left_position, right_position} <= 64'h0;
		{left_servo_busy, right_servo_busy} <= 2'h3;
		{left_servo_cmd, right_servo_cmd} <= 3'h0;
		{left_speed, right_speed, left_set_speed, right_set_speed} <= 56'h0;
		{left_max_speed, left_min_speed} <= 28'h0000000;
		{right_max_speed, right_min_speed} <= 28'h0000000;
		{left_running, left_cw, left_coast} <= 3'h0;
		{right_running, right_cw, right_coast} <= 3'h0;
		port_pins <= 8'h00;
	endtask : drive_quiet

	task automatic drive_random(input int k);
		for (int i = 0; i < 8; i++) r[i] = $random(seed);
		@(posedge clk);
		{left_dio_mode, right_dio_mode, links_preserved} <= r[0][2:0];
		{left_out_short, left_out_overcur} <= r[0][6:3];
		{right_out_short, right_out_overcur} <= r[0][10:7];
		{up_state_valid, dn_state_valid, track_valid} <= r[0][13:11];
		up_state_code <= {5'h00, 3'(k % 6 + 1)};
		dn_state_code <= {5'h00, 3'((k + 3) % 6 + 1)};
		{track_one, track_two} <= r[1];
		{left_position, right_position} <= r[2];
		{left_servo_busy, right_servo_busy} <= r[3][1:0];
		{left_servo_cmd, right_servo_cmd} <= r[3][4:2];
		{left_running, left_cw, left_coast} <= r[3][7:5];
		{right_running, right_cw, right_coast} <= r[3][10:8];
		port_pins <= r[3][18:11];
		{left_speed, right_speed} <= {r[4][13:0], r[5][13:0]};
		left_set_speed <= (k == 1) ? r[6][13:0] : r[4][27:14];
		right_set_speed <= (k == 2) ? r[7][27:14] : r[5][27:14];
		{left_max_speed, left_min_speed} <= r[6][27:0];
		{right_max_speed, right_min_speed} <= r[7][27:0];
		if (r[0][0] && r[0][11]) {t1_exp, t2_exp} = r[1];
		if (r[0][0] && r[0][13]) up_exp = {5'h00, 3'(k % 6 + 1)};
		if (r[0][0] && r[0][12]) dn_exp = {5'h00, 3'((k + 3) % 6 + 1)};
		@(posedge clk);
		{up_state_valid, dn_state_valid, track_valid} <= 3'h0;
	endtask : drive_random

	////////////////////////////////////////////////////////////////////////
	initial begin
		seed = 69;
		rstn = 1'b0;
		{up_exp, dn_exp, pol_mask, t1_exp, t2_exp} = 56'h0;
		drive_quiet();
		repeat (4) @(posedge clk);
		rstn <= 1'b1;
		for (int k = 0; k < 24; k++) begin
			drive_random(k);
			pol_mask = 8'($random(seed));
			plc_master_model_inst.bus_write(OFS_POL_MASK, {8'h00, pol_mask});
			plc_master_model_inst.bus_write(OFS_LEFT_DIO + 12'(k % 13),
				16'hFFFF);
			for (int a = 'h6B0; a <= 'h6C5; a++) begin
				if (a == 'h6C2) continue;
				plc_master_model_inst.bus_read(12'(a), got);
				check16("image_word", exp_word(12'(a)), got);
			end
			plc_master_model_inst.bus_read(12'hFFF, got);
			check16("unmapped", 16'h0000, got);
			check16("leds", {8'h00, port_pins ^ pol_mask}, {8'h00, input_leds});
			check1("irq_masked_off", 1'b0, irq);
		end
		@(posedge clk);
		drive_quiet();
		repeat (3) @(posedge clk);
		plc_master_model_inst.bus_read(OFS_IRQ_STATUS, got);
		plc_master_model_inst.bus_read(OFS_IRQ_STATUS, got);
		check16("status_idle", 16'h0000, got);
		plc_master_model_inst.bus_write(OFS_IRQ_MASK, 16'h0011);
		@(posedge clk);
		{left_dio_mode, left_out_short} <= 3'b110;
		repeat (3) @(posedge clk);
		#1 check1("irq_short", 1'b1, irq);
		@(posedge clk);
		left_dio_mode <= 1'b0;
		repeat (2) @(posedge clk);
		plc_master_model_inst.bus_read(OFS_IRQ_STATUS, got);
		check16("status_short", 16'h0001, got);
		repeat (2) @(posedge clk);
		#1 check1("irq_cleared", 1'b0, irq);
		@(posedge clk);
		{right_dio_mode, right_out_overcur} <= 3'b101;
		repeat (3) @(posedge clk);
		#1 check1("irq_overcur_masked", 1'b0, irq);
		@(posedge clk);
		right_dio_mode <= 1'b0;
		left_servo_busy <= 1'b0;
		repeat (3) @(posedge clk);
		#1 check1("irq_done", 1'b1, irq);
		plc_master_model_inst.bus_read(OFS_IRQ_STATUS, got);
		check16("status_done", 16'h0018, got);
		plc_master_model_inst.bus_read(OFS_IRQ_MASK, got);
		check16("irq_mask", 16'h0011, got);
		#1 check1("irq_done_cleared", 1'b0, irq);
		complete_run();
	end

endmodule : test_plc_input_status_image
